// File: verilog/ocfp_output_ctrl.sv
/*
 Output clock and frame pulse control registers and the control levels
 they drive into the analog output stage. Holds the 8-bit register file,
 multi-byte latching, and derived frequency/enable/delay controls.
 Assumes a byte-wide register port synchronous to sys_clk, from the
 serial interface decoder, and an active-high asynchronous reset.
*/
// Notes on behaviour
// - SONET codes map to eight listed frequencies
// - Low-speed Ethernet codes give five frequencies
// - High-speed Ethernet gives 156.25 or 312.5 MHz
// - Synth frequency is N times 8 kHz
// - Synth clock spans 2 kHz to 100 MHz
// - Frame rate code selects listed rates
// - Frame width code selects reference period
// - Frame pulse style, edge, polarity selectable
// - Cleared squelch forces APLL clock static
// - Cleared run bit holds synth clock low
// - Cleared enable tri-states each output
// - Enable bits power down APLL, synthesizer
// - Tx delay is signed 119.2 ps steps
// - APLL and synth have own fine delay
// - Coarse phase shifts by quarter periods
// - Differential delay has four settings
// - Frame delay 16-bit in 262.144 MHz steps
// - Frame delay in 125 us frame steps
// - Source bit picks Tx or Rx DPLL
// - Multi-byte values latch on top byte
// - APLL defaults SONET, Ethernet bits switch
`timescale 1ns/1ps
`include "ocfp_regs.svh"
module ocfp_output_ctrl import ocfp_pkg::*; #(
	parameter int MULT_WIDTH = 16,
	parameter int FINE_WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic synth_enable,
	output logic synth_source_rx,
	output logic synth_clk_run,
	output logic synth_clk_oe,
	output logic [MULT_WIDTH-1:0] synth_mult,
	output logic [31:0] synth_freq_hz,
	output logic synth_freq_invalid,
	output logic [1:0] synth_phase_quadrant,
	output logic [7:0] synth_fine_delay,
	output logic [3:0] frame_rate_code,
	output logic [31:0] frame_rate_mhz,
	output logic frame_rate_reserved,
	output logic [2:0] frame_width_code,
	output logic frame_width_reserved,
	output logic frame_style_clock,
	output logic frame_edge_falling,
	output logic frame_polarity_neg,
	output logic [FINE_WIDTH-1:0] frame_delay_fine,
	output logic [5:0] frame_delay_frames,
	output logic apll_enable,
	output logic apll_clk_run,
	output logic apll_clk_oe,
	output logic [1:0] apll_phase_quadrant,
	output logic [7:0] apll_fine_delay,
	output logic diff_oe,
	output logic [1:0] diff_adjust_code,
	output logic [2:0] diff_sel_code,
	output logic [31:0] diff_freq_khz,
	output logic diff_freq_reserved,
	output logic [7:0] tx_path_delay
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] soe; // Synth output enable
		logic [7:0] srun; // Synth run
		logic [7:0] mult_lo_shadow; // Low byte waiting for high byte
		logic [MULT_WIDTH-1:0] mult; // Committed multiplier
		logic [7:0] scoarse; // Synth coarse phase
		logic [7:0] sfine; // Synth fine delay
		logic [7:0] fp_rate; // Frame pulse rate
		logic [7:0] fp_shape; // Frame pulse shape
		logic [7:0] fd_lo_shadow; // Frame delay low byte pending
		logic [7:0] fd_hi_shadow; // Frame delay middle byte pending
		logic [FINE_WIDTH-1:0] fd_fine; // Committed fine frame delay
		logic [7:0] fd_coarse; // Committed coarse frame delay
		logic [7:0] aoe; // APLL output enable
		logic [7:0] arun; // APLL run control
		logic [7:0] acoarse; // APLL coarse phase
		logic [7:0] afine; // APLL fine delay
		logic [7:0] diff; // Differential control
		logic [7:0] txd; // Tx path delay
		logic [MULT_WIDTH-1:0] mult_rd; // Read snapshot of multiplier
		logic [23:0] fd_rd; // Read snapshot of frame delay
		logic [7:0] rdata; // Read data register
	} ocfp_state_type;

	ocfp_state_type state_reg; // Registered state
	ocfp_state_type state_next; // Next state
	ocfp_group_type diff_group; // Differential frequency group
	logic [31:0] mult_hz; // Product of N and base rate

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Frame rate in millihertz so 166.6667 Hz stays exact enough
	function automatic logic [31:0] ocfp_rate_mhz(input logic [3:0] code);
		logic [31:0] r;
		r = 32'h0;
		unique case (code)
			4'h0: r = 32'd166667;
			4'h1: r = 32'd400000;
			4'h2: r = 32'd1000000;
			4'h3: r = 32'd2000000;
			4'h4: r = 32'd4000000;
			4'h5: r = 32'd8000000;
			4'h6: r = 32'd32000000;
			4'h7: r = 32'd64000000;
			4'h8: r = 32'd1000;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// Byte read with a default of zero for unmapped addresses
	function automatic logic [7:0] ocfp_read(input ocfp_state_type s, input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			`OCFP_SYNTH_OUTPUT_ENABLE: d = s.soe;
			`OCFP_SYNTH_OUTPUT_RUN: d = s.srun;
			`OCFP_SYNTH_MULT_LOW: d = s.mult[7:0];
			`OCFP_SYNTH_MULT_HIGH: d = s.mult_rd[15:8];
			`OCFP_SYNTH_COARSE_PHASE: d = s.scoarse;
			`OCFP_SYNTH_FINE_DELAY: d = s.sfine;
			`OCFP_FRAME_PULSE_RATE: d = s.fp_rate;
			`OCFP_FRAME_PULSE_SHAPE: d = s.fp_shape;
			`OCFP_FRAME_DELAY_FINE_LOW: d = s.fd_fine[7:0];
			`OCFP_FRAME_DELAY_FINE_HIGH: d = s.fd_rd[15:8];
			`OCFP_FRAME_DELAY_COARSE: d = s.fd_rd[23:16];
			`OCFP_APLL_OUTPUT_ENABLE: d = s.aoe;
			`OCFP_APLL_RUN_CONTROL: d = s.arun;
			`OCFP_APLL_COARSE_PHASE: d = s.acoarse;
			`OCFP_APLL_FINE_DELAY: d = s.afine;
			`OCFP_DIFF_OUTPUT_CONTROL: d = s.diff;
			`OCFP_TX_PATH_DELAY: d = s.txd;
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Register writes, multi-byte commit and read snapshots
	always_comb begin
		state_next = state_reg;
		if (reg_rd) begin
			state_next.rdata = ocfp_read(state_reg, reg_addr);
			// Reading the low byte freezes upper bytes until the next low byte read
			if (reg_addr == `OCFP_SYNTH_MULT_LOW) begin
				state_next.mult_rd = state_reg.mult;
			end
			if (reg_addr == `OCFP_FRAME_DELAY_FINE_LOW) begin
				state_next.fd_rd = {state_reg.fd_coarse, state_reg.fd_fine};
			end
		end
		if (reg_wr) begin
			unique case (reg_addr)
				`OCFP_SYNTH_OUTPUT_ENABLE: state_next.soe = reg_wdata;
				`OCFP_SYNTH_OUTPUT_RUN: state_next.srun = reg_wdata;
				`OCFP_SYNTH_MULT_LOW: state_next.mult_lo_shadow = reg_wdata;
				// Low and high bytes commit together so N never glitches
				`OCFP_SYNTH_MULT_HIGH: state_next.mult = {reg_wdata, state_reg.mult_lo_shadow};
				`OCFP_SYNTH_COARSE_PHASE: state_next.scoarse = reg_wdata;
				`OCFP_SYNTH_FINE_DELAY: state_next.sfine = reg_wdata;
				`OCFP_FRAME_PULSE_RATE: state_next.fp_rate = reg_wdata;
				`OCFP_FRAME_PULSE_SHAPE: state_next.fp_shape = reg_wdata;
				`OCFP_FRAME_DELAY_FINE_LOW: state_next.fd_lo_shadow = reg_wdata;
				`OCFP_FRAME_DELAY_FINE_HIGH: state_next.fd_hi_shadow = reg_wdata;
				// Top byte commits all three bytes of frame delay
				`OCFP_FRAME_DELAY_COARSE: begin
					state_next.fd_fine = {state_reg.fd_hi_shadow, state_reg.fd_lo_shadow};
					state_next.fd_coarse = reg_wdata;
				end
				`OCFP_APLL_OUTPUT_ENABLE: state_next.aoe = reg_wdata;
				`OCFP_APLL_RUN_CONTROL: state_next.arun = reg_wdata;
				`OCFP_APLL_COARSE_PHASE: state_next.acoarse = reg_wdata;
				`OCFP_APLL_FINE_DELAY: state_next.afine = reg_wdata;
				`OCFP_DIFF_OUTPUT_CONTROL: state_next.diff = reg_wdata;
				`OCFP_TX_PATH_DELAY: state_next.txd = reg_wdata;
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Defaults: outputs enabled and running, SONET group, zero delays
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.soe <= `OCFP_RST_SYNTH_EN;
			state_reg.srun <= `OCFP_RST_RUN;
			state_reg.aoe <= `OCFP_RST_APLL_EN;
			state_reg.arun <= `OCFP_RST_APLL_RUN;
			state_reg.diff <= `OCFP_RST_DIFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Differential frequency decode
	// ----------------------------------------------------------------
	// Ethernet bit picks the group; group bit picks low or high speed
	always_comb begin
		if (!state_reg.arun[`OCFP_ARUN_ETH_EN_BIT]) begin
			diff_group = OCFP_GRP_SONET;
		end else if (state_reg.arun[`OCFP_ARUN_FSEL_DIFF_BIT]) begin
			diff_group = OCFP_GRP_ETH_LOW;
		end else begin
			diff_group = OCFP_GRP_ETH_HIGH;
		end
	end

	ocfp_freq_decode u_diff_decode (
		.sel(state_reg.diff[`OCFP_DIFF_SEL_LSB +: 3]),
		.group(diff_group),
		.freq_khz(diff_freq_khz),
		.reserved(diff_freq_reserved)
	);

	// ----------------------------------------------------------------
	// Synthesizer frequency
	// ----------------------------------------------------------------
	// N of zero is the special 2 kHz case; above 100 MHz is flagged
	assign mult_hz = 32'(state_reg.mult) * 32'(`OCFP_BASE_KHZ * 1000);
	always_comb begin
		if (state_reg.mult == '0) begin
			synth_freq_hz = 32'(`OCFP_ZERO_N_HZ);
		end else begin
			synth_freq_hz = mult_hz;
		end
		synth_freq_invalid = (mult_hz > 32'(`OCFP_MAX_SYNTH_KHZ * 1000));
	end

	// ----------------------------------------------------------------
	// Output assignments
	// ----------------------------------------------------------------
	assign reg_rdata = state_reg.rdata;
	assign synth_enable = state_reg.soe[`OCFP_SOE_SYNTH_EN_BIT];
	assign synth_source_rx = state_reg.soe[`OCFP_SOE_SOURCE_BIT];
	// Run needs the synthesizer powered, else clock is held low
	assign synth_clk_run = state_reg.srun[`OCFP_RUN_CLK_BIT] & synth_enable;
	assign synth_clk_oe = state_reg.soe[`OCFP_SOE_CLK_EN_BIT];
	assign synth_mult = state_reg.mult;
	assign synth_phase_quadrant = state_reg.scoarse[1:0];
	assign synth_fine_delay = state_reg.sfine;
	assign frame_rate_code = state_reg.fp_rate[3:0];
	assign frame_rate_mhz = ocfp_rate_mhz(state_reg.fp_rate[3:0]);
	assign frame_rate_reserved = (state_reg.fp_rate[3:0] > 4'h8);
	assign frame_width_code = state_reg.fp_shape[`OCFP_SHAPE_WIDTH_LSB +: 3];
	// Reserved widths flagged; host is expected never to use them
	assign frame_width_reserved = (frame_width_code == 3'(OCFP_W_RSV5)) ||
		(frame_width_code == 3'(OCFP_W_RSV6));
	assign frame_style_clock = state_reg.fp_shape[`OCFP_SHAPE_STYLE_BIT];
	assign frame_edge_falling = state_reg.fp_shape[`OCFP_SHAPE_EDGE_BIT];
	assign frame_polarity_neg = state_reg.fp_shape[`OCFP_SHAPE_POL_BIT];
	assign frame_delay_fine = state_reg.fd_fine;
	assign frame_delay_frames = state_reg.fd_coarse[5:0];
	assign apll_enable = state_reg.aoe[`OCFP_AOE_APLL_EN_BIT];
	// Squelch bit cleared, or APLL powered down, parks the clock
	assign apll_clk_run = state_reg.arun[`OCFP_ARUN_CLK_BIT] & apll_enable;
	assign apll_clk_oe = state_reg.aoe[`OCFP_AOE_CLK_EN_BIT];
	assign apll_phase_quadrant = state_reg.acoarse[1:0];
	assign apll_fine_delay = state_reg.afine;
	assign diff_oe = state_reg.diff[`OCFP_DIFF_EN_BIT];
	assign diff_adjust_code = state_reg.diff[`OCFP_DIFF_ADJ_LSB +: 2];
	assign diff_sel_code = state_reg.diff[`OCFP_DIFF_SEL_LSB +: 3];
	assign tx_path_delay = state_reg.txd;

endmodule

// File: verilog/ocfp_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 output clock and frame pulse control block. Assumes an 8-bit register port.
*/
`ifndef OCFP_REGS_SVH
`define OCFP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (7-bit register address)
// ----------------------------------------------------------------
`define OCFP_SYNTH_OUTPUT_ENABLE 7'h36
`define OCFP_SYNTH_OUTPUT_RUN 7'h37
`define OCFP_SYNTH_MULT_LOW 7'h38
`define OCFP_SYNTH_MULT_HIGH 7'h39
`define OCFP_SYNTH_COARSE_PHASE 7'h3A
`define OCFP_SYNTH_FINE_DELAY 7'h3D
`define OCFP_FRAME_PULSE_RATE 7'h3E
`define OCFP_FRAME_PULSE_SHAPE 7'h3F
`define OCFP_FRAME_DELAY_FINE_LOW 7'h40
`define OCFP_FRAME_DELAY_FINE_HIGH 7'h41
`define OCFP_FRAME_DELAY_COARSE 7'h42
`define OCFP_APLL_OUTPUT_ENABLE 7'h50
`define OCFP_APLL_RUN_CONTROL 7'h51
`define OCFP_APLL_COARSE_PHASE 7'h53
`define OCFP_APLL_FINE_DELAY 7'h55
`define OCFP_DIFF_OUTPUT_CONTROL 7'h60
`define OCFP_TX_PATH_DELAY 7'h63

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCFP_SOE_CLK_EN_BIT 0
`define OCFP_SOE_SYNTH_EN_BIT 1
`define OCFP_SOE_SOURCE_BIT 2
`define OCFP_RUN_CLK_BIT 0
`define OCFP_AOE_CLK_EN_BIT 0
`define OCFP_AOE_APLL_EN_BIT 1
`define OCFP_ARUN_CLK_BIT 0
`define OCFP_ARUN_ETH_EN_BIT 1
`define OCFP_ARUN_FSEL_BIT 2
`define OCFP_ARUN_FSEL_DIFF_BIT 3
`define OCFP_DIFF_EN_BIT 0
`define OCFP_DIFF_ADJ_LSB 1
`define OCFP_DIFF_SEL_LSB 4
`define OCFP_SHAPE_WIDTH_LSB 0
`define OCFP_SHAPE_STYLE_BIT 3
`define OCFP_SHAPE_EDGE_BIT 4
`define OCFP_SHAPE_POL_BIT 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCFP_RST_SYNTH_EN 8'h03
`define OCFP_RST_RUN 8'h01
`define OCFP_RST_APLL_EN 8'h03
`define OCFP_RST_APLL_RUN 8'h01
`define OCFP_RST_DIFF 8'h01
`define OCFP_RST_ZERO 8'h00

// ----------------------------------------------------------------
// Timing: base rate, frame length, kHz units in 1 kHz counts
// ----------------------------------------------------------------
`define OCFP_BASE_KHZ 8
`define OCFP_ZERO_N_HZ 2000
`define OCFP_MAX_SYNTH_KHZ 100000
`define OCFP_FRAME_US 125
`define OCFP_COARSE_FRAMES_MAX 64

`endif

// File: verilog/ocfp_pkg.sv
/*
 Types for the output clock and frame pulse control block.
 Assumes ocfp_regs.svh supplies the numbers.
*/
package ocfp_pkg;

	// Differential frequency group chosen by mode bits
	typedef enum logic [1:0] {
		OCFP_GRP_SONET,
		OCFP_GRP_ETH_LOW,
		OCFP_GRP_ETH_HIGH
	} ocfp_group_type;

	// Frame pulse width reference
	typedef enum logic [2:0] {
		OCFP_W_4M,
		OCFP_W_8M,
		OCFP_W_16M,
		OCFP_W_32M,
		OCFP_W_65M,
		OCFP_W_RSV5,
		OCFP_W_RSV6,
		OCFP_W_SYNTH
	} ocfp_width_type;

endpackage

// File: verilog/ocfp_freq_decode.sv
/*
 Combinational decode of the differential clock select into a frequency
 in kHz, with a reserved flag. Assumes mode bits come from registers.
*/
`timescale 1ns/1ps
module ocfp_freq_decode import ocfp_pkg::*; (
	input wire logic [2:0] sel,
	input wire ocfp_group_type group,
	output logic [31:0] freq_khz,
	output logic reserved
);

	// ----------------------------------------------------------------
	// Lookup per frequency group
	// ----------------------------------------------------------------
	always_comb begin
		freq_khz = 32'h0;
		reserved = 1'b0;
		unique case (group)
			OCFP_GRP_SONET: begin
				unique case (sel)
					3'h0: freq_khz = 32'd19440;
					3'h1: freq_khz = 32'd38880;
					3'h2: freq_khz = 32'd77760;
					3'h3: freq_khz = 32'd155520;
					3'h4: freq_khz = 32'd311040;
					3'h5: freq_khz = 32'd622080;
					3'h6: freq_khz = 32'd6480;
					3'h7: freq_khz = 32'd51840;
				endcase
			end
			OCFP_GRP_ETH_LOW: begin
				unique case (sel)
					3'h1: freq_khz = 32'd125000;
					3'h2: freq_khz = 32'd62500;
					3'h5: freq_khz = 32'd50000;
					3'h6: freq_khz = 32'd25000;
					3'h7: freq_khz = 32'd12500;
					default: reserved = 1'b1;
				endcase
			end
			OCFP_GRP_ETH_HIGH: begin
				unique case (sel)
					3'h3: freq_khz = 32'd156250;
					3'h4: freq_khz = 32'd312500;
					default: reserved = 1'b1;
				endcase
			end
			default: reserved = 1'b1;
		endcase
	end

endmodule

// File: dv/ocfp_phy_sink.sv
/*
 Behavioural clock consumer standing at the far side of the outputs.
 Assumes level controls from the output control block, one clock domain.
*/
`timescale 1ns/1ps
module ocfp_phy_sink (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic diff_oe,
	input wire logic apll_clk_oe,
	input wire logic apll_clk_run,
	input wire logic synth_clk_oe,
	input wire logic synth_clk_run,
	output logic clock_seen
);
	// ----------------------------------------------------------------
	// Receiver view: a clock only arrives when driven and toggling
	// ----------------------------------------------------------------
	// Registered so the view lags one cycle, like a real input stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clock_seen <= 1'b0;
		end else begin
			clock_seen <= diff_oe | (apll_clk_oe & apll_clk_run) | (synth_clk_oe & synth_clk_run);
		end
	end
endmodule

// File: dv/ocfp_output_ctrl_asserts.sv
/*
 Concurrent checks on the output control ports.
 Assumes binding onto ocfp_output_ctrl; one clock, reset active high.
*/
`timescale 1ns/1ps
module ocfp_checker import ocfp_pkg::*; #(
	parameter int MULT_WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic synth_enable,
	input wire logic synth_clk_run,
	input wire logic [MULT_WIDTH-1:0] synth_mult,
	input wire logic [31:0] synth_freq_hz,
	input wire logic apll_enable,
	input wire logic apll_clk_run,
	input wire logic [3:0] frame_rate_code,
	input wire logic frame_rate_reserved,
	input wire logic [7:0] tx_path_delay
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// Multi-byte commit steps
	// ----------------------------------------------------------------
	sequence s_mult_pair;
		reg_wr && reg_addr == 7'h38 ##1 reg_wr && reg_addr == 7'h39;
	endsequence
	a_mult_pair_low: assert property (s_mult_pair |=> synth_mult[7:0] == $past(reg_wdata, 2))
		else $error("low multiplier byte not committed");
	a_mult_hold: assert property (!(reg_wr && reg_addr == 7'h39) |=> $stable(synth_mult))
		else $error("multiplier moved without a top byte write");
	// ----------------------------------------------------------------
	// Frequency and gating relations
	// ----------------------------------------------------------------
	a_zero_n_rate: assert property (synth_mult == '0 |-> synth_freq_hz == 32'h7D0)
		else $error("zero multiplier not at lowest rate");
	a_freq_scale: assert property (synth_mult != '0 |-> synth_freq_hz == 32'(synth_mult) * 32'h1F40)
		else $error("synth rate not multiplier times base");
	a_synth_run_gate: assert property (!synth_enable |-> !synth_clk_run)
		else $error("synth clock runs while synthesizer off");
	a_apll_run_gate: assert property (!apll_enable |-> !apll_clk_run)
		else $error("apll clock runs while apll off");
	a_rate_reserved: assert property (frame_rate_reserved == (frame_rate_code > 4'h8))
		else $error("frame rate reserved flag wrong");
	// ----------------------------------------------------------------
	// Register port timing
	// ----------------------------------------------------------------
	a_tx_write: assert property (reg_wr && reg_addr == 7'h63 |=> tx_path_delay == $past(reg_wdata))
		else $error("tx delay not taken from write");
	a_read_tx: assert property (reg_rd && !reg_wr && reg_addr == 7'h63 |=> reg_rdata == tx_path_delay)
		else $error("tx delay readback wrong");
	a_rdata_hold: assert property (!reg_rd [*2] |-> $stable(reg_rdata))
		else $error("read data moved without a read");
endmodule
bind ocfp_output_ctrl ocfp_checker #(.MULT_WIDTH(MULT_WIDTH)) i_chk (.sys_clk(sys_clk), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .synth_enable(synth_enable), .synth_clk_run(synth_clk_run),
	.synth_mult(synth_mult), .synth_freq_hz(synth_freq_hz), .apll_enable(apll_enable),
	.apll_clk_run(apll_clk_run), .frame_rate_code(frame_rate_code),
	.frame_rate_reserved(frame_rate_reserved), .tx_path_delay(tx_path_delay));

// File: dv/ocfp_output_ctrl_tb_top.sv
/*
 Self-checking bench for the output control registers.
 Assumes the byte register port of ocfp_output_ctrl and a 100 ns clock.
*/
`timescale 1ns/1ps
module ocfp_output_ctrl_tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, d, v;
	logic [7:0] reg_rdata, synth_fine_delay, apll_fine_delay, tx_path_delay;
	logic synth_enable, synth_source_rx, synth_clk_run, synth_clk_oe, synth_freq_invalid;
	logic frame_rate_reserved, frame_width_reserved, frame_style_clock, frame_edge_falling;
	logic frame_polarity_neg, apll_enable, apll_clk_run, apll_clk_oe, diff_oe, diff_freq_reserved;
	logic clock_seen;
	logic [1:0] synth_phase_quadrant, apll_phase_quadrant, diff_adjust_code;
	logic [2:0] frame_width_code, diff_sel_code;
	logic [3:0] frame_rate_code;
	logic [5:0] frame_delay_frames;
	logic [15:0] synth_mult, frame_delay_fine, n, prev;
	logic [31:0] synth_freq_hz, frame_rate_mhz, diff_freq_khz, e, rng = 32'h83AE;
	int mismatches = 0, total_checks = 0;
	// Rows: SONET, low-speed Ethernet, high-speed Ethernet; zero marks reserved
	logic [31:0] khz_tbl [3][8] = '{'{32'h4BF0, 32'h97E0, 32'h12FC0, 32'h25F80, 32'h4BF00,
		32'h97E00, 32'h1950, 32'hCA80}, '{32'h0, 32'h1E848, 32'hF424, 32'h0, 32'h0, 32'hC350,
		32'h61A8, 32'h30D4}, '{32'h0, 32'h0, 32'h0, 32'h2625A, 32'h4C4B4, 32'h0, 32'h0, 32'h0}};
	logic [7:0] grp_tbl [3] = '{8'h01, 8'h0B, 8'h03};
	// Frame rates in millihertz
	logic [31:0] rate_tbl [9] = '{32'h28B0B, 32'h61A80, 32'hF4240, 32'h1E8480, 32'h3D0900,
		32'h7A1200, 32'h1E84800, 32'h3D09000, 32'h3E8};
	logic [6:0] addr_tbl [18] = '{7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3D, 7'h3E, 7'h3F, 7'h40,
		7'h41, 7'h42, 7'h50, 7'h51, 7'h53, 7'h55, 7'h60, 7'h63, 7'h01};

	ocfp_output_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.synth_enable(synth_enable), .synth_source_rx(synth_source_rx),
		.synth_clk_run(synth_clk_run), .synth_clk_oe(synth_clk_oe), .synth_mult(synth_mult),
		.synth_freq_hz(synth_freq_hz), .synth_freq_invalid(synth_freq_invalid),
		.synth_phase_quadrant(synth_phase_quadrant), .synth_fine_delay(synth_fine_delay),
		.frame_rate_code(frame_rate_code), .frame_rate_mhz(frame_rate_mhz),
		.frame_rate_reserved(frame_rate_reserved), .frame_width_code(frame_width_code),
		.frame_width_reserved(frame_width_reserved), .frame_style_clock(frame_style_clock),
		.frame_edge_falling(frame_edge_falling), .frame_polarity_neg(frame_polarity_neg),
		.frame_delay_fine(frame_delay_fine), .frame_delay_frames(frame_delay_frames),
		.apll_enable(apll_enable), .apll_clk_run(apll_clk_run), .apll_clk_oe(apll_clk_oe),
		.apll_phase_quadrant(apll_phase_quadrant), .apll_fine_delay(apll_fine_delay),
		.diff_oe(diff_oe), .diff_adjust_code(diff_adjust_code), .diff_sel_code(diff_sel_code),
		.diff_freq_khz(diff_freq_khz), .diff_freq_reserved(diff_freq_reserved),
		.tx_path_delay(tx_path_delay));
	ocfp_phy_sink i_phy (.sys_clk(sys_clk), .rst(rst), .diff_oe(diff_oe),
		.apll_clk_oe(apll_clk_oe), .apll_clk_run(apll_clk_run), .synth_clk_oe(synth_clk_oe),
		.synth_clk_run(synth_clk_run), .clock_seen(clock_seen));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Defaults: enables and run bits set, everything else clear
	function automatic logic [7:0] rst_val(input logic [6:0] a);
		return (a == 7'h36 || a == 7'h50) ? 8'h03 : (a == 7'h37 || a == 7'h51 || a == 7'h60) ? 8'h01 : 8'h00;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One byte write; outputs settle just after the taking edge
	task automatic wr(input logic [6:0] a, input logic [7:0] w);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Read data is registered at the taking edge
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	// Cuts a hang short well inside the cycle budget
	initial begin
		repeat (50000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end
	initial begin
		// Four cycles active-high hold, above the minimum width
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			rd(addr_tbl[i], d);
			chk(d, rst_val(addr_tbl[i]));
		end
		chk(synth_freq_hz, 32'h7D0);
		chk(32'(clock_seen), 32'h1);
		// Unmapped write must be dropped
		wr(7'h01, 8'hFF);
		rd(7'h01, d);
		chk(d, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(7'h36, 8'(i[2:0]));
			wr(7'h37, 8'(i[3]));
			wr(7'h50, 8'(i[1:0]));
			wr(7'h51, 8'(i[3]));
			chk({synth_source_rx, synth_enable, synth_clk_oe}, i[2:0]);
			chk({apll_enable, apll_clk_oe}, i[1:0]);
			chk({synth_clk_run, apll_clk_run}, {2{i[3] & i[1]}});
		end
		for (int g = 0; g < 3; g++) for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			wr(7'h51, grp_tbl[g]);
			wr(7'h60, {1'b0, i[2:0], 1'b0, rng[1:0], rng[2]});
			chk({diff_oe, diff_adjust_code, diff_sel_code}, {rng[2:0], i[2:0]});
			e = khz_tbl[g][i];
			chk(diff_freq_reserved, e == 32'h0);
			if (e != 32'h0) chk(diff_freq_khz, e);
		end
		for (int i = 0; i < 16; i++) begin
			wr(7'h3E, 8'(i));
			chk({frame_rate_code, frame_rate_reserved}, {i[3:0], i > 8});
			if (i <= 8) chk(frame_rate_mhz, rate_tbl[i]);
		end
		for (int i = 0; i < 64; i++) begin
			wr(7'h3F, 8'(i));
			chk(frame_width_reserved, i[2:0] == 3'h5 || i[2:0] == 3'h6);
			chk({frame_polarity_neg, frame_edge_falling, frame_style_clock}, i[5:3]);
			chk(frame_width_code, i[2:0]);
		end
		// Multiplier: zero, both sides of the 100 MHz limit, then random
		prev = 16'h0000;
		for (int k = 0; k < 24; k++) begin
			rng = xs(rng);
			n = (k == 0) ? 16'h0000 : (k == 1) ? 16'h30D4 : (k == 2) ? 16'h30D5 : rng[15:0];
			wr(7'h38, n[7:0]);
			chk(synth_mult, prev);
			wr(7'h39, n[15:8]);
			chk(synth_mult, n);
			chk(synth_freq_hz, (n == 16'h0) ? 32'h7D0 : n * 32'h1F40);
			chk(synth_freq_invalid, n * 32'h1F40 > 32'h5F5E100);
			rd(7'h38, d);
			rd(7'h39, v);
			chk({v, d}, n);
			prev = n;
		end
		// Frame delay bytes commit only on the top byte; starts from reset zero
		prev = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			v = (k == 0) ? 8'h3F : rng[23:16];
			wr(7'h40, rng[7:0]);
			wr(7'h41, rng[15:8]);
			chk(frame_delay_fine, prev);
			wr(7'h42, v);
			chk({frame_delay_fine, frame_delay_frames}, {rng[15:0], v[5:0]});
			prev = rng[15:0];
		end
		// Signed delays, both extremes then random
		for (int k = 0; k < 3; k++) begin
			rng = xs(rng);
			v = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : rng[7:0];
			wr(7'h3A, v);
			wr(7'h3D, v);
			wr(7'h53, ~v);
			wr(7'h55, ~v);
			wr(7'h63, v);
			chk({synth_phase_quadrant, apll_phase_quadrant}, {v[1:0], ~v[1:0]});
			chk({synth_fine_delay, apll_fine_delay}, {v, ~v});
			rd(7'h63, d);
			chk({d, tx_path_delay}, {v, v});
		end
		complete_run();
	end
endmodule
